// *** hw/xeo_pkg.sv ***
// Constants for the exclusive-NOR, configuration word and EEPROM load unit
package xeo_pkg;
    // ****************************************
    // Data widths and register selection
    // ****************************************
    localparam int XEO_DW = 24;
    localparam int XEO_AW = 13;
    localparam int XEO_PW = 8;
    localparam logic [1:0] XEO_REG_X = 2'h0;
    localparam logic [1:0] XEO_REG_Y = 2'h1;
    localparam logic [1:0] XEO_REG_Z = 2'h2;
    localparam logic [1:0] XEO_REG_R = 2'h3;
    localparam logic [XEO_DW-1:0] XEO_ZERO = 24'h00_0000;
    // ****************************************
    // Memory image layout
    // ****************************************
    localparam int XEO_CFG_WORDS = 16;
    localparam int XEO_CFG_BYTES_PER_WORD = 3;
    localparam logic [XEO_AW-1:0] XEO_CFG_BASE = 13'h0000;
    localparam logic [XEO_AW-1:0] XEO_CODE_BASE = 13'h0030;
    // ****************************************
    // Instruction lengths in bytes and cycles
    // ****************************************
    localparam logic [2:0] XEO_XNR_REG_BYTES = 3'h2;
    localparam logic [2:0] XEO_XNR_IMM_BYTES = 3'h5;
    localparam logic [2:0] XEO_CFG_BYTES = 3'h3;
    localparam logic [2:0] XEO_LDE_BYTES = 3'h1;
    localparam logic [2:0] XEO_XNR_REG_CYC = 3'h3;
    localparam logic [2:0] XEO_XNR_IMM_CYC = 3'h6;
    localparam logic [2:0] XEO_LDE_CYC = 3'h6;
    localparam logic [2:0] XEO_CYC_ONE = 3'h1;
    // ****************************************
    // Operations and sequencer states
    // ****************************************
    typedef enum logic [1:0]
    {
        XEO_OP_XNR_REG = 2'h0,
        XEO_OP_XNR_IMM = 2'h1,
        XEO_OP_CFG = 2'h2,
        XEO_OP_LDE = 2'h3
    } xeo_op_t;
    typedef enum logic [2:0]
    {
        XEO_ST_IDLE = 3'b001,
        XEO_ST_RUN = 3'b010,
        XEO_ST_DONE = 3'b100
    } xeo_state_t;
endpackage

// *** hw/xeo_flags.sv ***
// Sign and nonzero flag evaluation of a working register value
`timescale 1ns/100ps
module xeo_flags
    import xeo_pkg::*;
(
    input wire logic [XEO_DW-1:0] value_i,
    output logic sign_o,
    output logic nonzero_o
);
    assign sign_o = value_i[XEO_DW-1];
    assign nonzero_o = (value_i != XEO_ZERO);
endmodule

// *** hw/xeo_unit.sv ***
// Execution unit for exclusive-NOR, configuration word and EEPROM load
//
// Overview of operation
// - Exclusive-NOR stores the bitwise equivalence and updates both flags.
// - Target is x, y, z or r; source is one of them or a 24-bit constant.
// - Exclusive-NOR is 2 bytes with a register source, 5 with a constant.
// - Exclusive-NOR takes 3 cycles on a register source, 6 on a constant.
// - A configuration word is 3 bytes, stored verbatim with flags untouched.
// - Image bytes 0 to 47 hold sixteen 24-bit configuration words for setup.
// - User code starts at byte 48, right after the configuration area.
// - EEPROM load copies the word at the RAM pointer and updates the flags.
// - EEPROM load is 1 byte long and completes in 6 cycles.
// - EEPROM load holds one stack entry while it runs and frees it after.
// - Sign is set for a negative value, nonzero for any value but zero.
`timescale 1ns/100ps
module xeo_unit
    import xeo_pkg::*;
(
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic start_i,
    input wire logic [1:0] op_i,
    input wire logic [1:0] dst_sel_i,
    input wire logic [1:0] src_sel_i,
    input wire logic [XEO_DW-1:0] imm_i,
    input wire logic [XEO_PW-1:0] ram_ptr_i,
    input wire logic [XEO_DW-1:0] eep_rdata_i,
    output logic busy_o,
    output logic done_o,
    output logic [2:0] op_bytes_o,
    output logic [XEO_DW-1:0] reg_x_o,
    output logic [XEO_DW-1:0] reg_y_o,
    output logic [XEO_DW-1:0] reg_z_o,
    output logic [XEO_DW-1:0] reg_r_o,
    output logic sign_o,
    output logic nonzero_o,
    output logic eep_rd_o,
    output logic [XEO_PW-1:0] eep_addr_o,
    output logic stack_hold_o,
    output logic cfg_we_o,
    output logic [XEO_AW-1:0] cfg_addr_o,
    output logic [XEO_DW-1:0] cfg_wdata_o,
    output logic cfg_full_o,
    output logic [XEO_AW-1:0] code_base_o
);
    // ****************************************
    // State and working registers
    // ****************************************
    xeo_state_t state_reg, state_next;
    xeo_op_t op_reg;
    logic [2:0] cnt_reg, cnt_next;
    logic [1:0] dst_reg;
    logic [XEO_DW-1:0] opb_reg;
    logic [XEO_DW-1:0] wreg_reg [4];
    logic sign_reg, nonzero_reg;
    logic busy_reg, done_reg, eep_rd_reg, stack_reg;
    logic [2:0] bytes_reg;
    logic [XEO_PW-1:0] eep_addr_reg;
    logic cfg_we_reg;
    logic [XEO_AW-1:0] cfg_addr_reg;
    logic [XEO_DW-1:0] cfg_wdata_reg;
    logic [4:0] cfg_count_reg;
    logic cfg_full_reg;

    // ****************************************
    // Decode
    // ****************************************
    wire logic is_imm = (op_i == XEO_OP_XNR_IMM);
    wire logic is_lde = (op_i == XEO_OP_LDE);
    wire logic is_cfg = (op_i == XEO_OP_CFG);
    // Constant form needs three extra fetch cycles for the immediate bytes
    wire logic [2:0] cyc_sel = is_imm ? XEO_XNR_IMM_CYC :
                              is_lde ? XEO_LDE_CYC :
                              XEO_XNR_REG_CYC;
    wire logic [2:0] bytes_sel = is_imm ? XEO_XNR_IMM_BYTES :
                                is_lde ? XEO_LDE_BYTES :
                                is_cfg ? XEO_CFG_BYTES :
                                XEO_XNR_REG_BYTES;
    wire logic [XEO_DW-1:0] opb_sel = is_imm ? imm_i
                                             : wreg_reg[src_sel_i];
    wire logic cfg_ok = (cfg_count_reg < 5'(XEO_CFG_WORDS));
    wire logic accept = (state_reg == XEO_ST_IDLE) && start_i;
    wire logic last = (state_reg == XEO_ST_RUN) && (cnt_reg == XEO_CYC_ONE);
    wire logic [XEO_DW-1:0] xnr_res = ~(wreg_reg[dst_reg] ^ opb_reg);
    wire logic [XEO_DW-1:0] result = (op_reg == XEO_OP_LDE) ? eep_rdata_i
                                                              : xnr_res;
    wire logic res_sign, res_nz;

    xeo_flags u_flags
    (
        .value_i(result),
        .sign_o(res_sign),
        .nonzero_o(res_nz)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    // Configuration words are a single store, so they never enter RUN
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            XEO_ST_IDLE:
            begin
                if (start_i && !is_cfg)
                begin
                    state_next = XEO_ST_RUN;
                    cnt_next = cyc_sel - XEO_CYC_ONE;
                end
            end
            XEO_ST_RUN:
            begin
                cnt_next = cnt_reg - XEO_CYC_ONE;
                if (cnt_reg == XEO_CYC_ONE)
                    state_next = XEO_ST_DONE;
            end
            XEO_ST_DONE:
                state_next = XEO_ST_IDLE;
            default:
                state_next = XEO_ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_reg <= XEO_ST_IDLE;
            cnt_reg <= 3'h0;
            op_reg <= XEO_OP_XNR_REG;
            dst_reg <= XEO_REG_X;
            opb_reg <= XEO_ZERO;
            bytes_reg <= 3'h0;
            eep_addr_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            if (accept)
            begin
                op_reg <= xeo_op_t'(op_i);
                dst_reg <= dst_sel_i;
                opb_reg <= opb_sel;
                bytes_reg <= bytes_sel;
                eep_addr_reg <= ram_ptr_i;
            end
        end
    end

    // ****************************************
    // Status pulses and stack hold
    // ****************************************
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            eep_rd_reg <= 1'b0;
            stack_reg <= 1'b0;
        end
        else
        begin
            busy_reg <= (state_next != XEO_ST_IDLE);
            done_reg <= last || (accept && is_cfg);
            eep_rd_reg <= accept && is_lde;
            // Held from issue to the final cycle of the load
            if (accept && is_lde)
                stack_reg <= 1'b1;
            else if (last)
                stack_reg <= 1'b0;
        end
    end

    // ****************************************
    // Working registers and flags
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_wreg
            always_ff @(posedge clock_i or negedge nrst_i)
            begin
                if (!nrst_i)
                    wreg_reg[gi] <= XEO_ZERO;
                else if (last && dst_reg == 2'(gi))
                    wreg_reg[gi] <= result;
            end
        end
    endgenerate

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sign_reg <= 1'b0;
            nonzero_reg <= 1'b0;
        end
        else if (last)
        begin
            sign_reg <= res_sign;
            nonzero_reg <= res_nz;
        end
    end

    // ****************************************
    // Configuration image writer
    // ****************************************
    // Extra words beyond the sixteenth are dropped so user code stays intact
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cfg_we_reg <= 1'b0;
            cfg_addr_reg <= XEO_CFG_BASE;
            cfg_wdata_reg <= XEO_ZERO;
            cfg_count_reg <= 5'h0;
            cfg_full_reg <= 1'b0;
        end
        else
        begin
            cfg_we_reg <= accept && is_cfg && cfg_ok;
            if (accept && is_cfg && cfg_ok)
            begin
                cfg_wdata_reg <= imm_i;
                cfg_addr_reg <= XEO_CFG_BASE + XEO_AW'(cfg_count_reg * 
                    XEO_CFG_BYTES_PER_WORD);
                cfg_count_reg <= cfg_count_reg + 5'h1;
                // Registered so the full flag leaves the block from a flop
                cfg_full_reg <= (cfg_count_reg + 5'h1 == 5'(XEO_CFG_WORDS));
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign busy_o = busy_reg;
    assign done_o = done_reg;
    assign op_bytes_o = bytes_reg;
    assign reg_x_o = wreg_reg[XEO_REG_X];
    assign reg_y_o = wreg_reg[XEO_REG_Y];
    assign reg_z_o = wreg_reg[XEO_REG_Z];
    assign reg_r_o = wreg_reg[XEO_REG_R];
    assign sign_o = sign_reg;
    assign nonzero_o = nonzero_reg;
    assign eep_rd_o = eep_rd_reg;
    assign eep_addr_o = eep_addr_reg;
    assign stack_hold_o = stack_reg;
    assign cfg_we_o = cfg_we_reg;
    assign cfg_addr_o = cfg_addr_reg;
    assign cfg_wdata_o = cfg_wdata_reg;
    assign cfg_full_o = cfg_full_reg;
    assign code_base_o = XEO_CODE_BASE;
endmodule

// *** verif/xeo_unit_monitor.sv ***
// Port checks for the execution unit
`timescale 1ns/100ps
module xeo_unit_monitor
    import xeo_pkg::*;
(
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic start_i,
    input wire logic [1:0] op_i,
    input wire logic [XEO_DW-1:0] imm_i,
    input wire logic [XEO_PW-1:0] ram_ptr_i,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic sign_o,
    input wire logic nonzero_o,
    input wire logic eep_rd_o,
    input wire logic [XEO_PW-1:0] eep_addr_o,
    input wire logic stack_hold_o,
    input wire logic cfg_we_o,
    input wire logic [XEO_AW-1:0] cfg_addr_o,
    input wire logic [XEO_DW-1:0] cfg_wdata_o,
    input wire logic cfg_full_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    // Done cycle is excluded too, though after a configuration word the unit still accepts a start there
    wire logic take = start_i && !busy_o && !done_o;
    sequence s_short; !done_o[*2] ##1 done_o; endsequence
    sequence s_long; !done_o[*5] ##1 done_o; endsequence
    sequence s_hold; stack_hold_o[*5] ##1 !stack_hold_o; endsequence
    chk_reg_cycles: assert property (
        take && op_i == XEO_OP_XNR_REG |-> ##1 s_short) else $error("reg len");
    chk_imm_cycles: assert property (
        take && op_i == XEO_OP_XNR_IMM |-> ##1 s_long) else $error("imm len");
    chk_load_cycles: assert property (
        take && op_i == XEO_OP_LDE |-> ##1 s_long) else $error("load len");
    chk_load_read: assert property (
        take && op_i == XEO_OP_LDE |-> ##1 eep_rd_o &&
        eep_addr_o == $past(ram_ptr_i)) else $error("load addr");
    chk_stack_hold: assert property (
        take && op_i == XEO_OP_LDE |-> ##1 s_hold) else $error("stack");
    chk_cfg_write: assert property (
        take && op_i == XEO_OP_CFG && !cfg_full_o |-> ##1 cfg_we_o &&
        cfg_wdata_o == $past(imm_i)) else $error("cfg write");
    chk_cfg_area: assert property (
        cfg_we_o |-> cfg_addr_o <= 13'h002d) else $error("cfg addr");
    chk_cfg_refuse: assert property (
        take && op_i == XEO_OP_CFG && cfg_full_o |-> ##1 !cfg_we_o)
        else $error("cfg over");
    chk_cfg_flags: assert property (
        take && op_i == XEO_OP_CFG |-> ##1 $stable({sign_o, nonzero_o}))
        else $error("cfg flags");
    chk_flag_cause: assert property (
        !$stable({sign_o, nonzero_o}) |-> done_o) else $error("flag time");
endmodule
bind xeo_unit xeo_unit_monitor xeo_unit_monitor_i (.clock_i(clock_i),
    .nrst_i(nrst_i), .start_i(start_i), .op_i(op_i), .imm_i(imm_i),
    .ram_ptr_i(ram_ptr_i), .busy_o(busy_o), .done_o(done_o),
    .sign_o(sign_o), .nonzero_o(nonzero_o), .eep_rd_o(eep_rd_o),
    .eep_addr_o(eep_addr_o), .stack_hold_o(stack_hold_o),
    .cfg_we_o(cfg_we_o), .cfg_addr_o(cfg_addr_o), .cfg_wdata_o(cfg_wdata_o),
    .cfg_full_o(cfg_full_o));

// *** verif/xeo_eep_model.sv ***
// Behavioural EEPROM that answers a read after a prompt or slow lag
`timescale 1ns/100ps
module xeo_eep_model
    import xeo_pkg::*;
(
    input wire logic clock_i,
    input wire logic rd_i,
    input wire logic slow_i,
    input wire logic [XEO_PW-1:0] addr_i,
    output logic [XEO_DW-1:0] rdata_o
);
    logic [2:0] age_reg;
    logic [XEO_DW-1:0] word_reg;
    wire logic [2:0] lag = slow_i ? 3'h4 : 3'h1;
    // Outside the valid window show the inverse, never a stale word
    assign rdata_o = (age_reg >= lag && age_reg <= 3'h4) ? word_reg
                                                         : ~word_reg;
    always_ff @(posedge clock_i)
    begin
        if (rd_i)
        begin
            age_reg <= 3'h1;
            word_reg <= {addr_i, ~addr_i, addr_i ^ 8'h5a};
        end
        else if (age_reg != 3'h0 && age_reg < 3'h6)
            age_reg <= age_reg + 3'h1;
        else
            age_reg <= 3'h0;
    end
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the execution unit
`timescale 1ns/100ps
module tb;
    import xeo_pkg::*;
    logic clk, rst_n, start, slow, busy, done, sign, nz, rd, hold, we, full;
    logic [1:0] op, dst, src;
    logic [23:0] imm, rdata, wdata, exp, im;
    logic [23:0] r[4];
    logic [23:0] m[4];
    logic [7:0] ptr, eaddr;
    logic [2:0] bytes;
    logic [12:0] caddr, cbase;
    int bad_count = 0;
    int n_tests = 0;
    int ncyc, nhold;
    wire logic [23:0] flags = {22'h0, sign, nz};
    xeo_unit xeo_unit_i (.clock_i(clk), .nrst_i(rst_n), .start_i(start),
        .op_i(op), .dst_sel_i(dst), .src_sel_i(src), .imm_i(imm),
        .ram_ptr_i(ptr), .eep_rdata_i(rdata), .busy_o(busy), .done_o(done),
        .op_bytes_o(bytes), .reg_x_o(r[0]), .reg_y_o(r[1]), .reg_z_o(r[2]),
        .reg_r_o(r[3]), .sign_o(sign), .nonzero_o(nz), .eep_rd_o(rd),
        .eep_addr_o(eaddr), .stack_hold_o(hold), .cfg_we_o(we),
        .cfg_addr_o(caddr), .cfg_wdata_o(wdata), .cfg_full_o(full),
        .code_base_o(cbase));
    xeo_eep_model xeo_eep_model_i (.clock_i(clk), .rd_i(rd), .slow_i(slow),
        .addr_i(eaddr), .rdata_o(rdata));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input string nm, input logic [23:0] seen, e);
        n_tests++;
        if (seen !== e)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic run(input logic [1:0] o, d, s, input logic [23:0] v,
        input logic [7:0] p);
        @(posedge clk);
        {start, op, dst, src, imm, ptr} <= {1'b1, o, d, s, v, p};
        @(posedge clk);
        start <= 1'b0;
        ncyc = 1;
        nhold = 0;
        #1;
        check("busy", 24'(busy), 24'(o != XEO_OP_CFG));
        while (done !== 1'b1 && ncyc < 20)
        begin
            nhold += int'(hold === 1'b1);
            @(posedge clk);
            #1 ncyc++;
        end
    endtask
    task automatic t_load;
        for (int d = 0; d < 4; d++)
        begin
            slow = d[0];
            m[d] = {8'h7e + d[7:0], ~(8'h7e + d[7:0]),
                (8'h7e + d[7:0]) ^ 8'h5a};
            run(XEO_OP_LDE, d[1:0], 2'h0, 24'h00_0000, 8'h7e + d[7:0]);
            check("load reg", r[d], m[d]);
            check("load cycles", 24'(ncyc), 24'h6);
            check("load bytes", 24'(bytes), 24'h1);
            check("load flags", flags, m[d][23] ? 24'h3 : 24'h1);
            check("stack held", 24'(nhold), 24'h5);
            check("stack freed", 24'(hold), 24'h0);
        end
    endtask
    task automatic t_xnor;
        for (int k = 0; k < 8; k++)
        begin
            im = k[0] ? 24'h5a_5a5a : ~m[k % 4];
            exp = ~(m[k % 4] ^ (k > 3 ? im : m[3 - k % 4]));
            run(k > 3 ? XEO_OP_XNR_IMM : XEO_OP_XNR_REG, 2'(k), 2'(3 - k),
                im, 8'h00);
            check("xnor dst", r[k % 4], exp);
            check("xnor src", r[3 - k % 4], m[3 - k % 4]);
            check("xnor cycles", 24'(ncyc), k > 3 ? 24'h6 : 24'h3);
            check("xnor bytes", 24'(bytes), k > 3 ? 24'h5 : 24'h2);
            check("xnor flags", flags, {22'h0, exp[23], exp != 0});
            m[k % 4] = exp;
        end
    endtask
    task automatic t_cfg;
        for (int i = 0; i < 17; i++)
        begin
            exp = flags;
            check("cfg full", 24'(full), 24'(i == 16));
            run(XEO_OP_CFG, 2'h0, 2'h0, {20'hc_0000, i[3:0]}, 8'h00);
            check("cfg write", 24'(we), 24'(i < 16));
            if (i < 16)
                check("cfg addr", 24'(caddr), 24'(3 * i));
            if (i < 16)
                check("cfg data", wdata, {20'hc_0000, i[3:0]});
            check("cfg flags", flags, exp);
            check("cfg bytes", 24'(bytes), 24'h3);
        end
        check("code base", 24'(cbase), 24'h30);
    endtask
    initial
    begin
        {rst_n, start, op, dst, src, imm, ptr, slow} = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_load;
        t_xnor;
        t_cfg;
        close_out;
    end
    initial
    begin
        #10000;
        bad_count++;
        close_out;
    end
endmodule
